// ### dv/ltr_regs_sva.sv
// assertion checker for the tone/ring config register bank
module ltr_regs_sva
  import ltr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic clock_divider_select,
  input wire logic bclk_decimal,
  input wire logic [1:0] pll_period_sel,
  input wire ltr_ctrl_t ctrl
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_take;
    psel && penable && !pready;
  endsequence
  sequence s_wr(logic [31:0] a);
    psel && penable && !pready && pwrite && pstrb[0] && paddr == a;
  endsequence

  a_ready_next: assert property (s_take |=> pready)
    else $error("access not answered in second cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held over one cycle");
  a_err_unmapped: assert property (s_take ##0 (paddr == 32'h2b8) |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_ro_write: assert property (s_wr(32'h2d4) |=> pready && !pslverr)
    else $error("write to count refused");
  a_temp_offset: assert property (s_wr(32'h2a8) |=> ##1
    ctrl.temp_threshold_degc == $signed({2'b00, $past(pwdata[7:0], 2)}) - 10'sd67)
    else $error("temperature threshold wrong");
  a_mask_time: assert property (s_wr(32'h2ac) |=> ##1
    ctrl.loop_close_mask_time == $past(pwdata[7:0], 2))
    else $error("mask time wrong");
  a_osc_ctrl: assert property (s_wr(32'h300) |=> ##1
    {ctrl.osc_two_zero_cross, ctrl.osc_one_zero_cross, ctrl.osc_two_enable, ctrl.osc_one_enable}
    == {$past(pwdata[5:4], 2), $past(pwdata[1:0], 2)})
    else $error("oscillator controls wrong");
  a_ring_ctrl: assert property (s_wr(32'h304) |=> ##1
    {ctrl.ring_shape_enable, ctrl.ring_shape_select, ctrl.ringer_one_enable, ctrl.tone_route_select}
    == {$past(pwdata[7:5], 2), $past(pwdata[3], 2)})
    else $error("ring controls wrong");
  a_dc_opts: assert property (s_wr(32'h2d0) |=> ##1
    {ctrl.extended_monitor_range, ctrl.low_battery_range, ctrl.driver_bias_tracking,
    ctrl.smoothing_cutoff_double} == $past(pwdata[7:4], 2))
    else $error("dc options wrong");
  a_init_low: assert property (s_wr(32'h308) |=> ##1
    ctrl.osc_one_initial_value[7:0] == $past(pwdata[7:0], 2))
    else $error("initial value low byte wrong");
  a_pll_sel: assert property ($stable({clock_divider_select, bclk_decimal})[*4] |->
    pll_period_sel == {clock_divider_select, bclk_decimal})
    else $error("pll period select wrong");
endmodule : ltr_regs_sva

bind ltr_regs ltr_regs_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
  .prdata, .pready, .pslverr, .clock_divider_select, .bclk_decimal, .pll_period_sel, .ctrl);

// ### dv/testbench.sv
// self-checking bench for the tone/ring config register bank
module testbench
  import ltr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, q;
  logic [3:0] pstrb = 4'h0;
  logic clock_divider_select = 1'b0, bclk_decimal = 1'b0, pready, pslverr, e;
  ltr_pwm_meas_t pwm_meas = 16'h2030;
  logic [1:0] pll_period_sel;
  ltr_ctrl_t ctrl;
  int err_total = 0, num_checks = 0, cyc = 0;

  ltr_regs dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .pwm_meas, .clock_divider_select, .bclk_decimal, .pll_period_sel, .ctrl);

  initial
  begin
    forever #5 pclk = ~pclk;
  end

  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    num_checks++;
    if (g !== x)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, x, g);
    end
  endtask : chk

  // one apb transfer; read data and error taken at the ready edge
  task automatic apb(input logic w, input logic [31:0] a, input logic [7:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    apb(1'b1, {22'h0, i, 2'b00}, d, 4'h1);
  endtask : wr

  task automatic rdchk(input string nm, input logic [7:0] i, input logic [7:0] x);
    apb(1'b0, {22'h0, i, 2'b00}, 8'h00, 4'h0);
    chk(nm, {24'h0, x}, q);
    chk("read_err", 32'h0, {31'h0, e});
  endtask : rdchk

  task automatic t_regs();
    logic [7:0] idx [15] = '{8'haa, 8'hab, 8'hac, 8'had, 8'haf, 8'hb0, 8'hb1, 8'hb4, 8'hb5,
      8'hc0, 8'hc1, 8'hc2, 8'hc3, 8'hc4, 8'hc5};
    logic [7:0] msk [15] = '{8'hff, 8'hff, 8'h0f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hf0, 8'h00,
      8'h33, 8'he8, 8'hff, 8'hff, 8'hff, 8'hff};
    logic [7:0] rst [15] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h77, 8'h97, 8'h79, 8'h00, 8'h20,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    foreach (idx[k])
    begin
      rdchk("reset", idx[k], rst[k]);
      wr(idx[k], 8'hff);
      rdchk("mask_ff", idx[k], msk[k] | (idx[k] == 8'hb5 ? 8'h20 : 8'h00));
      wr(idx[k], 8'h5a);
      rdchk("mask_5a", idx[k], (msk[k] & 8'h5a) | (idx[k] == 8'hb5 ? 8'h20 : 8'h00));
    end
  endtask : t_regs

  task automatic t_ctrl();
    @(posedge pclk);
    chk("temp", 32'd23, {22'h0, ctrl.temp_threshold_degc});
    chk("times", 32'h5a5a, {16'h0, ctrl.loop_close_mask_time, ctrl.ring_phase_delay});
    chk("trims", 32'h5a5a5a5, {4'h0, ctrl.coarse_trim, ctrl.internal_resistor_select, ctrl.battery_voltage_trim,
      ctrl.sense_a_trim, ctrl.sense_b_trim, ctrl.tip_voltage_trim, ctrl.ring_voltage_trim,
      ctrl.common_mode_trim});
    chk("options", 32'ha6a, {20'h0, ctrl.smoothing_cutoff_double, ctrl.driver_bias_tracking, ctrl.low_battery_range,
      ctrl.extended_monitor_range, ctrl.osc_one_enable, ctrl.osc_two_enable, ctrl.osc_one_zero_cross,
      ctrl.osc_two_zero_cross, ctrl.tone_route_select, ctrl.ringer_one_enable, ctrl.ring_shape_select,
      ctrl.ring_shape_enable});
    wr(8'haa, 8'h00);
    @(posedge pclk);
    chk("temp_min", 32'h3bd, {22'h0, ctrl.temp_threshold_degc});
    wr(8'haa, 8'hff);
    @(posedge pclk);
    chk("temp_max", 32'h0bc, {22'h0, ctrl.temp_threshold_degc});
    wr(8'hc2, 8'h34);
    wr(8'hc3, 8'h12);
    wr(8'hc4, 8'h78);
    wr(8'hc5, 8'h56);
    @(posedge pclk);
    chk("init", 32'h12345678, {ctrl.osc_one_initial_value, ctrl.osc_two_initial_value});
  endtask : t_ctrl

  // software side: nonzero phase delay only with zero crossing, zero delay for tones
  task automatic t_phase();
    wr(8'hc0, 8'h22);
    wr(8'had, 8'h10);
    @(posedge pclk);
    chk("phase_zc", 32'h110, {23'h0, ctrl.osc_two_zero_cross, ctrl.ring_phase_delay});
    wr(8'had, 8'h00);
    @(posedge pclk);
    chk("phase_tone", 32'h100, {23'h0, ctrl.osc_two_enable, ctrl.ring_phase_delay});
  endtask : t_phase

  task automatic t_err();
    apb(1'b0, 32'h2b8, 8'h00, 4'h0);
    chk("unmapped", 32'h1, {31'h0, e});
    chk("unmapped_data", 32'h0, q);
    apb(1'b0, 32'h2a9, 8'h00, 4'h0);
    chk("misaligned", 32'h1, {31'h0, e});
    apb(1'b1, 32'h4000_02a8, 8'h11, 4'h1);
    chk("high_addr", 32'h1, {31'h0, e});
    apb(1'b1, 32'h2ac, 8'h22, 4'h0);
    rdchk("after_high", 8'haa, 8'hff);
    rdchk("strobe_off", 8'hab, 8'h5a);
  endtask : t_err

  task automatic t_pwm();
    pwm_meas <= 16'h4030;
    rdchk("pwm_clip", 8'hb5, 8'h30);
    pwm_meas <= 16'h0030;
    rdchk("pwm_zero", 8'hb5, 8'h00);
  endtask : t_pwm

  task automatic t_pll();
    for (int k = 0; k < 4; k++)
    begin
      @(posedge pclk);
      {clock_divider_select, bclk_decimal} <= k[1:0];
      repeat (4) @(posedge pclk);
      chk("pll_sel", {30'h0, k[1:0]}, {30'h0, pll_period_sel});
    end
  endtask : t_pll

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_total++;
      complete_run();
    end
  end

  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_ctrl();
    t_err();
    t_pwm();
    t_pll();
    t_phase();
    complete_run();
  end
endmodule : testbench

// ### hdl/ltr_pkg.sv
// package: register map, field positions, reset values and bus types for the tone/ring config bank
package ltr_pkg;

  // register indices; offsets are not word multiples, so byte address = 4 * index
  localparam logic [7:0] LTR_IDX_TEMP_ALARM_THRESHOLD = 8'haa;
  localparam logic [7:0] LTR_IDX_LOOP_CLOSURE_MASK_COUNT = 8'hab;
  localparam logic [7:0] LTR_IDX_COARSE_CAL_TRIM = 8'hac;
  localparam logic [7:0] LTR_IDX_OSC2_RING_PHASE_DELAY = 8'had;
  localparam logic [7:0] LTR_IDX_CAL_TRIM_ONE = 8'haf;
  localparam logic [7:0] LTR_IDX_CAL_TRIM_TWO = 8'hb0;
  localparam logic [7:0] LTR_IDX_CAL_TRIM_THREE = 8'hb1;
  localparam logic [7:0] LTR_IDX_DC_OFFSET_OPTIONS = 8'hb4;
  localparam logic [7:0] LTR_IDX_PWM_ON_TIME_COUNT = 8'hb5;
  localparam logic [7:0] LTR_IDX_OSCILLATOR_CONTROL = 8'hc0;
  localparam logic [7:0] LTR_IDX_RING_CONTROL = 8'hc1;
  localparam logic [7:0] LTR_IDX_OSC1_INIT_LOW = 8'hc2;
  localparam logic [7:0] LTR_IDX_OSC1_INIT_HIGH = 8'hc3;
  localparam logic [7:0] LTR_IDX_OSC2_INIT_LOW = 8'hc4;
  localparam logic [7:0] LTR_IDX_OSC2_INIT_HIGH = 8'hc5;

  // writable-bit masks; zero bits are reserved
  localparam logic [7:0] LTR_MASK_COARSE_CAL_TRIM = 8'h0f;
  localparam logic [7:0] LTR_MASK_DC_OFFSET_OPTIONS = 8'hf0;
  localparam logic [7:0] LTR_MASK_OSCILLATOR_CONTROL = 8'h33;
  localparam logic [7:0] LTR_MASK_RING_CONTROL = 8'he8;

  // reset values
  localparam logic [7:0] LTR_RST_ZERO = 8'h00;
  localparam logic [7:0] LTR_RST_CAL_TRIM_ONE = 8'h77;
  localparam logic [7:0] LTR_RST_CAL_TRIM_TWO = 8'h97;
  localparam logic [7:0] LTR_RST_CAL_TRIM_THREE = 8'h79;

  // field positions
  localparam int LTR_BIT_INTERNAL_RESISTOR_SELECT = 3;
  localparam int LTR_BIT_SMOOTHING_CUTOFF_DOUBLE = 4;
  localparam int LTR_BIT_DRIVER_BIAS_TRACKING = 5;
  localparam int LTR_BIT_LOW_BATTERY_RANGE = 6;
  localparam int LTR_BIT_EXTENDED_MONITOR_RANGE = 7;
  localparam int LTR_BIT_OSC_ONE_ENABLE = 0;
  localparam int LTR_BIT_OSC_TWO_ENABLE = 1;
  localparam int LTR_BIT_OSC_ONE_ZERO_CROSS = 4;
  localparam int LTR_BIT_OSC_TWO_ZERO_CROSS = 5;
  localparam int LTR_BIT_TONE_ROUTE_SELECT = 3;
  localparam int LTR_BIT_RINGER_ONE_ENABLE = 5;
  localparam int LTR_BIT_RING_SHAPE_SELECT = 6;
  localparam int LTR_BIT_RING_SHAPE_ENABLE = 7;

  // field scaling
  localparam logic signed [9:0] LTR_TEMP_OFFSET_DEGC = 10'sd67;
  localparam int LTR_MASK_STEP_US_X100 = 125;
  localparam int LTR_PHASE_STEP_US = 125;

  localparam logic [31:0] LTR_APB_ERR_DATA = 32'h0000_0000;

  // pwm on-time measurement from the dc/dc controller
  typedef struct packed {
    logic [7:0] pulse_on_time;
    logic [7:0] pulse_limit;
  } ltr_pwm_meas_t;

  // decoded controls to the analog and tone blocks
  typedef struct packed {
    logic signed [9:0] temp_threshold_degc;
    logic [7:0] loop_close_mask_time;
    logic [2:0] coarse_trim;
    logic internal_resistor_select;
    logic [7:0] ring_phase_delay;
    logic [3:0] battery_voltage_trim;
    logic [3:0] sense_a_trim;
    logic [3:0] sense_b_trim;
    logic [3:0] tip_voltage_trim;
    logic [3:0] ring_voltage_trim;
    logic [3:0] common_mode_trim;
    logic smoothing_cutoff_double;
    logic driver_bias_tracking;
    logic low_battery_range;
    logic extended_monitor_range;
    logic osc_one_enable;
    logic osc_two_enable;
    logic osc_one_zero_cross;
    logic osc_two_zero_cross;
    logic tone_route_select;
    logic ringer_one_enable;
    logic ring_shape_select;
    logic ring_shape_enable;
    logic [15:0] osc_one_initial_value;
    logic [15:0] osc_two_initial_value;
  } ltr_ctrl_t;

endpackage : ltr_pkg

// ### hdl/ltr_regs.sv
// register bank for temperature alarm, calibration trims, dc options, pwm count and tone/ring controls
// Summary of operation
// - temperature threshold in degrees is the field minus 67, one degree steps
// - loop closure mask count is a time in 1.25 us units, 0 to 319 us
// - oscillator 2 ring phase delay counts 125 us steps, up to 31.9 ms
// - pwm on-time count is read-only; on-time is count times pll period
// - reported on-time is limited to zero through period minus off-time
// - pll period chosen from clock divider select and binary or decimal bit clock
// - oscillator control bits 0 and 1 enable oscillators 1 and 2
// - oscillator control bits 4 and 5 enable zero crossing of oscillators 1 and 2
// - ring control bit 3 routes tones to transmit when 0, receive when 1
// - ring control bit 5 enables ringer 1
// - ring control bit 6 picks sine or trapezoid, bit 7 enables the select
// - offset control bit 4 doubles the smoothing filter cutoff
// - offset control bit 5 makes driver bias track coarse calibration
// - offset bit 6 picks low battery range, bit 7 extended monitor range
// - oscillator initial values are 16 bits, low byte at lower address
// - six 4-bit trims in three registers reset to 77, 97 and 79 hex
// - coarse trim in bits 2..0, internal resistor select in bit 3
//
// Local design decision: the APB interface to the registers.
module ltr_regs
  import ltr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ltr_pwm_meas_t pwm_meas,
  input wire logic clock_divider_select,
  input wire logic bclk_decimal,
  output logic [1:0] pll_period_sel,
  output ltr_ctrl_t ctrl
);

  logic [7:0] temp_alarm_threshold_reg;
  logic [7:0] loop_closure_mask_count_reg;
  logic [7:0] coarse_cal_trim_reg;
  logic [7:0] osc2_ring_phase_delay_reg;
  logic [7:0] cal_trim_one_reg;
  logic [7:0] cal_trim_two_reg;
  logic [7:0] cal_trim_three_reg;
  logic [7:0] dc_offset_options_reg;
  logic [7:0] pwm_on_time_count_reg;
  logic [7:0] oscillator_control_reg;
  logic [7:0] ring_control_reg;
  logic [7:0] osc1_init_low_reg;
  logic [7:0] osc1_init_high_reg;
  logic [7:0] osc2_init_low_reg;
  logic [7:0] osc2_init_high_reg;
  logic [7:0] pwm_on_time_next;
  logic [1:0] pll_sync1_reg;
  logic [1:0] pll_sync2_reg;
  logic [7:0] rd_byte;
  logic hit;
  logic wr_en;
  logic [7:0] wb;
  logic [7:0] idx;
  logic take;

  assign idx = paddr[9:2];
  // a transfer is taken in its first access cycle, before its own ready pulse
  assign take = psel && penable && !pready;
  assign wr_en = take && pwrite && pstrb[0] && hit;
  assign wb = pwdata[7:0];

  always_comb
  begin
    hit = 1'b1;
    rd_byte = LTR_RST_ZERO;
    unique case (idx)
      LTR_IDX_TEMP_ALARM_THRESHOLD: rd_byte = temp_alarm_threshold_reg;
      LTR_IDX_LOOP_CLOSURE_MASK_COUNT: rd_byte = loop_closure_mask_count_reg;
      LTR_IDX_COARSE_CAL_TRIM: rd_byte = coarse_cal_trim_reg;
      LTR_IDX_OSC2_RING_PHASE_DELAY: rd_byte = osc2_ring_phase_delay_reg;
      LTR_IDX_CAL_TRIM_ONE: rd_byte = cal_trim_one_reg;
      LTR_IDX_CAL_TRIM_TWO: rd_byte = cal_trim_two_reg;
      LTR_IDX_CAL_TRIM_THREE: rd_byte = cal_trim_three_reg;
      LTR_IDX_DC_OFFSET_OPTIONS: rd_byte = dc_offset_options_reg;
      LTR_IDX_PWM_ON_TIME_COUNT: rd_byte = pwm_on_time_count_reg;
      LTR_IDX_OSCILLATOR_CONTROL: rd_byte = oscillator_control_reg;
      LTR_IDX_RING_CONTROL: rd_byte = ring_control_reg;
      LTR_IDX_OSC1_INIT_LOW: rd_byte = osc1_init_low_reg;
      LTR_IDX_OSC1_INIT_HIGH: rd_byte = osc1_init_high_reg;
      LTR_IDX_OSC2_INIT_LOW: rd_byte = osc2_init_low_reg;
      LTR_IDX_OSC2_INIT_HIGH: rd_byte = osc2_init_high_reg;
      default: hit = 1'b0;
    endcase
    if (paddr[1:0] != 2'b00 || paddr[31:10] != 22'h0)
    begin
      hit = 1'b0;
    end
  end

  // apb answer: pready pulses one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= take;
      pslverr <= take && !hit;
    end
  end

  // read data stands only while pready is high, zero otherwise
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= LTR_APB_ERR_DATA;
    end
    else
    begin
      if (take && !pwrite && hit)
      begin
        prdata <= {24'h0, rd_byte};
      end
      else
      begin
        prdata <= LTR_APB_ERR_DATA;
      end
    end
  end

  // plain read/write threshold, mask, delay and calibration registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      temp_alarm_threshold_reg <= LTR_RST_ZERO;
      loop_closure_mask_count_reg <= LTR_RST_ZERO;
      coarse_cal_trim_reg <= LTR_RST_ZERO;
      osc2_ring_phase_delay_reg <= LTR_RST_ZERO;
      cal_trim_one_reg <= LTR_RST_CAL_TRIM_ONE;
      cal_trim_two_reg <= LTR_RST_CAL_TRIM_TWO;
      cal_trim_three_reg <= LTR_RST_CAL_TRIM_THREE;
    end
    else if (wr_en)
    begin
      unique case (idx)
        LTR_IDX_TEMP_ALARM_THRESHOLD: temp_alarm_threshold_reg <= wb;
        LTR_IDX_LOOP_CLOSURE_MASK_COUNT: loop_closure_mask_count_reg <= wb;
        LTR_IDX_COARSE_CAL_TRIM: coarse_cal_trim_reg <= wb & LTR_MASK_COARSE_CAL_TRIM;
        LTR_IDX_OSC2_RING_PHASE_DELAY: osc2_ring_phase_delay_reg <= wb;
        LTR_IDX_CAL_TRIM_ONE: cal_trim_one_reg <= wb;
        LTR_IDX_CAL_TRIM_TWO: cal_trim_two_reg <= wb;
        LTR_IDX_CAL_TRIM_THREE: cal_trim_three_reg <= wb;
        default:
        begin
        end
      endcase
    end
  end

  // option and tone/ring control registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dc_offset_options_reg <= LTR_RST_ZERO;
      oscillator_control_reg <= LTR_RST_ZERO;
      ring_control_reg <= LTR_RST_ZERO;
    end
    else if (wr_en)
    begin
      unique case (idx)
        LTR_IDX_DC_OFFSET_OPTIONS: dc_offset_options_reg <= wb & LTR_MASK_DC_OFFSET_OPTIONS;
        LTR_IDX_OSCILLATOR_CONTROL: oscillator_control_reg <= wb & LTR_MASK_OSCILLATOR_CONTROL;
        LTR_IDX_RING_CONTROL: ring_control_reg <= wb & LTR_MASK_RING_CONTROL;
        default:
        begin
        end
      endcase
    end
  end

  // oscillator initial value bytes; each byte is written on its own
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      osc1_init_low_reg <= LTR_RST_ZERO;
      osc1_init_high_reg <= LTR_RST_ZERO;
      osc2_init_low_reg <= LTR_RST_ZERO;
      osc2_init_high_reg <= LTR_RST_ZERO;
    end
    else if (wr_en)
    begin
      unique case (idx)
        LTR_IDX_OSC1_INIT_LOW: osc1_init_low_reg <= wb;
        LTR_IDX_OSC1_INIT_HIGH: osc1_init_high_reg <= wb;
        LTR_IDX_OSC2_INIT_LOW: osc2_init_low_reg <= wb;
        LTR_IDX_OSC2_INIT_HIGH: osc2_init_high_reg <= wb;
        default:
        begin
        end
      endcase
    end
  end

  // pll period select inputs come from another domain: two flops first
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pll_sync1_reg <= 2'b00;
      pll_sync2_reg <= 2'b00;
      pll_period_sel <= 2'b00;
    end
    else
    begin
      pll_sync1_reg <= {clock_divider_select, bclk_decimal};
      pll_sync2_reg <= pll_sync1_reg;
      pll_period_sel <= pll_sync2_reg;
    end
  end

  // on-time clipped to the allowed window; bus writes never reach it
  always_comb
  begin
    pwm_on_time_next = pwm_meas.pulse_on_time;
    if (pwm_meas.pulse_on_time > pwm_meas.pulse_limit)
    begin
      pwm_on_time_next = pwm_meas.pulse_limit;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pwm_on_time_count_reg <= LTR_RST_ZERO;
    end
    else
    begin
      pwm_on_time_count_reg <= pwm_on_time_next;
    end
  end

  // temperature, mask time and phase delay controls, one edge after the register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl.temp_threshold_degc <= '0;
      ctrl.loop_close_mask_time <= '0;
      ctrl.ring_phase_delay <= '0;
    end
    else
    begin
      ctrl.temp_threshold_degc <= $signed({2'b00, temp_alarm_threshold_reg}) - LTR_TEMP_OFFSET_DEGC;
      ctrl.loop_close_mask_time <= loop_closure_mask_count_reg;
      ctrl.ring_phase_delay <= osc2_ring_phase_delay_reg;
    end
  end

  // coarse calibration trim and internal resistor select
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl.coarse_trim <= '0;
      ctrl.internal_resistor_select <= '0;
    end
    else
    begin
      ctrl.coarse_trim <= coarse_cal_trim_reg[2:0];
      ctrl.internal_resistor_select <= coarse_cal_trim_reg[LTR_BIT_INTERNAL_RESISTOR_SELECT];
    end
  end

  // six calibration trim nibbles
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl.battery_voltage_trim <= '0;
      ctrl.sense_a_trim <= '0;
      ctrl.sense_b_trim <= '0;
      ctrl.tip_voltage_trim <= '0;
      ctrl.ring_voltage_trim <= '0;
      ctrl.common_mode_trim <= '0;
    end
    else
    begin
      ctrl.battery_voltage_trim <= cal_trim_one_reg[3:0];
      ctrl.sense_a_trim <= cal_trim_one_reg[7:4];
      ctrl.sense_b_trim <= cal_trim_two_reg[3:0];
      ctrl.tip_voltage_trim <= cal_trim_two_reg[7:4];
      ctrl.ring_voltage_trim <= cal_trim_three_reg[3:0];
      ctrl.common_mode_trim <= cal_trim_three_reg[7:4];
    end
  end

  // filter, bias and dc range options
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl.smoothing_cutoff_double <= '0;
      ctrl.driver_bias_tracking <= '0;
      ctrl.low_battery_range <= '0;
      ctrl.extended_monitor_range <= '0;
    end
    else
    begin
      ctrl.smoothing_cutoff_double <= dc_offset_options_reg[LTR_BIT_SMOOTHING_CUTOFF_DOUBLE];
      ctrl.driver_bias_tracking <= dc_offset_options_reg[LTR_BIT_DRIVER_BIAS_TRACKING];
      ctrl.low_battery_range <= dc_offset_options_reg[LTR_BIT_LOW_BATTERY_RANGE];
      ctrl.extended_monitor_range <= dc_offset_options_reg[LTR_BIT_EXTENDED_MONITOR_RANGE];
    end
  end

  // oscillator enables and zero crossing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl.osc_one_enable <= '0;
      ctrl.osc_two_enable <= '0;
      ctrl.osc_one_zero_cross <= '0;
      ctrl.osc_two_zero_cross <= '0;
    end
    else
    begin
      ctrl.osc_one_enable <= oscillator_control_reg[LTR_BIT_OSC_ONE_ENABLE];
      ctrl.osc_two_enable <= oscillator_control_reg[LTR_BIT_OSC_TWO_ENABLE];
      ctrl.osc_one_zero_cross <= oscillator_control_reg[LTR_BIT_OSC_ONE_ZERO_CROSS];
      ctrl.osc_two_zero_cross <= oscillator_control_reg[LTR_BIT_OSC_TWO_ZERO_CROSS];
    end
  end

  // tone route, ringer enable and ring shape
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl.tone_route_select <= '0;
      ctrl.ringer_one_enable <= '0;
      ctrl.ring_shape_select <= '0;
      ctrl.ring_shape_enable <= '0;
    end
    else
    begin
      ctrl.tone_route_select <= ring_control_reg[LTR_BIT_TONE_ROUTE_SELECT];
      ctrl.ringer_one_enable <= ring_control_reg[LTR_BIT_RINGER_ONE_ENABLE];
      ctrl.ring_shape_select <= ring_control_reg[LTR_BIT_RING_SHAPE_SELECT];
      ctrl.ring_shape_enable <= ring_control_reg[LTR_BIT_RING_SHAPE_ENABLE];
    end
  end

  // oscillator initial values, high byte over low byte
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl.osc_one_initial_value <= '0;
      ctrl.osc_two_initial_value <= '0;
    end
    else
    begin
      ctrl.osc_one_initial_value <= {osc1_init_high_reg, osc1_init_low_reg};
      ctrl.osc_two_initial_value <= {osc2_init_high_reg, osc2_init_low_reg};
    end
  end

endmodule : ltr_regs
